/* File: rtl/supervisor_map.vh */
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH
`define CLK_HZ 40000000
`define RESET_TIMEOUT_MS 200
`define WATCHDOG_PERIOD_MS 1600
`define RESET_TIMEOUT_CYCLES ((`CLK_HZ / 1000) * `RESET_TIMEOUT_MS)
`define WATCHDOG_PERIOD_CYCLES ((`CLK_HZ / 1000) * `WATCHDOG_PERIOD_MS)
`define DEBOUNCE_CYCLES 32'h00009C40
`define SYNC_INIT 7'h47
`define TIMER_WIDTH 32
`endif

/* File: rtl/sync_two_stage.v */
`timescale 1ns/10ps
`default_nettype none
module sync_two_stage #(
  parameter WIDTH = 5,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          stage_one[i] <= INIT[i];
          sync_out[i] <= INIT[i];
        end else if (clk_en) begin
          stage_one[i] <= async_in[i];
          sync_out[i] <= stage_one[i];
        end
      end
    end
  endgenerate
endmodule // sync_two_stage
`default_nettype wire

/* File: rtl/supply_supervisor_reset_watchdog.v */
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_map.vh"
module supply_supervisor_reset_watchdog #(
  parameter [31:0] RESET_TIMEOUT_CYCLES = `RESET_TIMEOUT_CYCLES,
  parameter [31:0] WATCHDOG_PERIOD_CYCLES = `WATCHDOG_PERIOD_CYCLES,
  parameter [31:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire supply_below_reset_level,
  input wire supply_below_switch_level,
  input wire supply_below_min_level,
  input wire backup_cell_above_supply,
  input wire power_fail_sense,
  input wire watchdog_kick_in,
  input wire manual_reset_n,
  output reg reset_out_n,
  output reg reset_high_out,
  output reg reset_high_oe,
  output reg power_fail_flag_n,
  output reg ram_on_backup
);
  // One-hot states; the reset output is released only in run
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_TIMEOUT = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  wire [6:0] sync_vec;
  wire s_low;
  wire s_sw;
  wire s_min;
  wire s_cell;
  wire s_pf;
  wire s_kick;
  wire s_mr_n;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] reset_count;
  reg [31:0] wd_count;
  reg [31:0] db_count;
  reg kick_prev;
  reg mr_stable_n;
  reg backup_mode;
  reg next_backup;
  reg hold_cause;
  reg wd_expired;
  reg next_reset_n;

  // Reset-state init: supply assumed low, manual released, kick low, so
  // reset stays held and no false kick edge appears just after release
  sync_two_stage #(
    .WIDTH(7),
    .INIT(`SYNC_INIT)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({manual_reset_n,
      watchdog_kick_in,
      power_fail_sense,
      backup_cell_above_supply,
      supply_below_min_level,
      supply_below_switch_level,
      supply_below_reset_level}),
    .sync_out(sync_vec)
  );
  assign s_low = sync_vec[0];
  assign s_sw = sync_vec[1];
  assign s_min = sync_vec[2];
  assign s_cell = sync_vec[3];
  assign s_pf = sync_vec[4];
  assign s_kick = sync_vec[5];
  assign s_mr_n = sync_vec[6];

  // Debounce: level must stand for DEBOUNCE_CYCLES before being accepted
  // Costs DEBOUNCE_CYCLES of latency on press and on release alike
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      db_count <= 32'h00000000;
      mr_stable_n <= 1'h1;
    end else if (clk_en) begin
      if (backup_mode) begin
        db_count <= 32'h00000000;
      end else if (s_mr_n == mr_stable_n) begin
        db_count <= 32'h00000000;
      end else if (db_count >= DEBOUNCE_CYCLES - 32'h00000001) begin
        db_count <= 32'h00000000;
        mr_stable_n <= s_mr_n;
      end else begin
        db_count <= db_count + 32'h00000001;
      end
    end
  end

  // Backup mode: entered per cell/supply, left only above the reset level
  // Entry wins over exit so a dip below the minimum is never lost
  always @* begin
    next_backup = backup_mode;
    if ((s_sw && s_cell) || s_min) begin
      next_backup = 1'h1;
    end else if (!s_low) begin
      next_backup = 1'h0;
    end
  end

  // Power-fail sense is deliberately absent from the hold causes
  always @* begin
    hold_cause = s_low || backup_mode || !mr_stable_n;
    wd_expired = (wd_count >= WATCHDOG_PERIOD_CYCLES - 32'h00000001);
  end

  // Any cause seen during the timeout falls back to hold, restarting the count
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!hold_cause) begin
          next_state = ST_TIMEOUT;
        end
      end
      ST_TIMEOUT: begin
        if (hold_cause) begin
          next_state = ST_HOLD;
        end else if (reset_count >= RESET_TIMEOUT_CYCLES - 32'h00000001) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hold_cause) begin
          next_state = ST_HOLD;
        end else if (wd_expired) begin
          next_state = ST_TIMEOUT;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
    next_reset_n = (next_state == ST_RUN);
  end

  // State register and backup latch
  // kick_prev follows the synchronised kick so each edge is seen once
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
      backup_mode <= 1'h1;
      kick_prev <= 1'h0;
    end else if (clk_en) begin
      state <= next_state;
      backup_mode <= next_backup;
      kick_prev <= s_kick;
    end
  end

  // Counter restarts from zero whenever a cause is present
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reset_count <= 32'h00000000;
    end else if (clk_en) begin
      if (next_state != ST_TIMEOUT || state != ST_TIMEOUT) begin
        reset_count <= 32'h00000000;
      end else begin
        reset_count <= reset_count + 32'h00000001;
      end
    end
  end

  // Watchdog held cleared outside run, so it counts from reset release
  // Limitation: kick pulses shorter than one clock may go unseen
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_count <= 32'h00000000;
    end else if (clk_en) begin
      if (state != ST_RUN || next_state != ST_RUN || s_kick != kick_prev) begin
        wd_count <= 32'h00000000;
      end else begin
        wd_count <= wd_count + 32'h00000001;
      end
    end
  end

  // Reset and backup outputs registered from next-state values so they move with the state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reset_out_n <= 1'h0;
      reset_high_out <= 1'h0;
      reset_high_oe <= 1'h0;
      power_fail_flag_n <= 1'h0;
      ram_on_backup <= 1'h1;
    end else if (clk_en) begin
      reset_out_n <= next_reset_n;
      // Open drain: only ever pulls low, released while reset asserted
      reset_high_out <= 1'h0;
      reset_high_oe <= next_reset_n;
      // Comparison forced off below switchover; no link to reset path
      power_fail_flag_n <= !(s_pf || s_sw);
      ram_on_backup <= next_backup;
    end
  end
endmodule // supply_supervisor_reset_watchdog
`default_nettype wire

/* File: tb/supervisor_chk_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module supervisor_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic supply_below_reset_level,
  input wire logic supply_below_switch_level,
  input wire logic supply_below_min_level,
  input wire logic power_fail_sense,
  input wire logic reset_out_n,
  input wire logic reset_high_out,
  input wire logic reset_high_oe,
  input wire logic power_fail_flag_n,
  input wire logic ram_on_backup
);
  default clocking @(posedge sys_clk); endclocking
  // A frozen clock enable holds every output, so checks pause with it
  default disable iff (sys_rst || !clk_en);
  a_oe_inverse: assert property (reset_high_oe == reset_out_n && !reset_high_out)
    else $error("oe wrong");
  a_supply_hold: assert property (supply_below_reset_level [*3] |=> !reset_out_n)
    else $error("no hold");
  a_pulse_min: assert property ($fell(reset_out_n) |-> !reset_out_n [*8])
    else $error("short pulse");
  a_pf_low: assert property ((power_fail_sense || supply_below_switch_level) [*4]
    |-> !power_fail_flag_n) else $error("pf high");
  a_pf_high: assert property (!(power_fail_sense || supply_below_switch_level) [*4]
    |-> power_fail_flag_n) else $error("pf low");
  a_min_backup: assert property (supply_below_min_level [*4] |-> ram_on_backup)
    else $error("no backup");
  a_rail_return: assert property ($fell(ram_on_backup)
    |-> !$past(supply_below_reset_level, 3)) else $error("early rail");
  a_rail_first: assert property ($fell(ram_on_backup) |-> !reset_out_n [*8])
    else $error("late rail");
endmodule // supervisor_chk
bind supply_supervisor_reset_watchdog supervisor_chk u_supervisor_chk (.*);
`default_nettype wire

/* File: tb/kick_firmware_model.sv */
`timescale 1ns/10ps
`default_nettype none
module kick_firmware_model (
  input wire logic sys_clk,
  input wire logic run,
  output var logic kick
);
  logic [3:0] tick = 4'h0;
  initial kick = 1'b0;
  // Toggles every 16 cycles, well inside the shortened watchdog period
  always @(posedge sys_clk) begin
    tick <= tick + 4'h1;
    if (run && tick == 4'hF) kick <= #1 ~kick;
  end
endmodule // kick_firmware_model
`default_nettype wire

/* File: tb/supply_supervisor_reset_watchdog_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_reset_watchdog_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b1;
  logic en = 1'b1;
  logic [5:0] v = 6'h21;
  logic kick, rst_n, oe, pf_n, bk;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  kick_firmware_model u_kick_firmware_model (.sys_clk, .run, .kick);
  supply_supervisor_reset_watchdog #(.RESET_TIMEOUT_CYCLES(32'h14),
    .WATCHDOG_PERIOD_CYCLES(32'h32), .DEBOUNCE_CYCLES(32'h4)) u_supply_supervisor_reset_watchdog (
    .sys_clk, .sys_rst, .clk_en(en), .supply_below_reset_level(v[5]),
    .supply_below_switch_level(v[4]), .supply_below_min_level(v[3]),
    .backup_cell_above_supply(v[2]), .power_fail_sense(v[1]), .watchdog_kick_in(kick),
    .manual_reset_n(v[0]), .reset_out_n(rst_n), .reset_high_out(), .reset_high_oe(oe),
    .power_fail_flag_n(pf_n), .ram_on_backup(bk));
  task automatic final_report(input int hung);
    n_mismatch += hung;
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] exp);
    total_checks++;
    if ({rst_n, oe, pf_n, bk} !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %b want %b", $time, {rst_n, oe, pf_n, bk}, exp);
    end
  endtask
  // Bits: supply low, switch low, min low, cell above, sense low, manual_n
  task automatic set(input logic [5:0] nv, input int n);
    v = nv;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) if (++cycles == 3000) final_report(1);
  task automatic t_supply;
    set(6'h01, 12);
    set(6'h21, 2);
    set(6'h01, 18);
    chk(4'h2);
    set(6'h01, 12);
    chk(4'hE);
    set(6'h03, 4);
    chk(4'hC);
  endtask
  task automatic t_watchdog;
    int i;
    run = 1'b0;
    for (i = 0; i < 90 && rst_n; i++) set(6'h01, 1);
    set(6'h01, 15);
    chk(4'h2);
    for (i = 0; i < 20 && !rst_n; i++) set(6'h01, 1);
    set(6'h01, 44);
    chk(4'hE);
    set(6'h01, 14);
    chk(4'h2);
    run = 1'b1;
    set(6'h01, 140);
    chk(4'hE);
  endtask
  task automatic t_manual;
    set(6'h00, 2);
    set(6'h01, 10);
    chk(4'hE);
    set(6'h00, 12);
    chk(4'h2);
    set(6'h01, 20);
    chk(4'h2);
    set(6'h01, 14);
    chk(4'hE);
  endtask
  task automatic t_backup;
    set(6'h31, 4);
    chk(4'h0);
    set(6'h39, 4);
    chk(4'h1);
    set(6'h21, 4);
    chk(4'h3);
    set(6'h01, 4);
    chk(4'h2);
    set(6'h14, 4);
    chk(4'h1);
    set(6'h01, 26);
    chk(4'hE);
    set(6'h01, 8);
    chk(4'hE);
  endtask
  // Clock enable low: a supply dip must leave every output frozen
  task automatic t_freeze;
    en = 1'b0;
    set(6'h21, 10);
    chk(4'hE);
    en = 1'b1;
    set(6'h01, 6);
    chk(4'hE);
  endtask
  initial begin
    set(6'h21, 20);
    sys_rst = 1'b0;
    t_supply;
    t_watchdog;
    t_manual;
    t_backup;
    t_freeze;
    final_report(0);
  end
endmodule // supply_supervisor_reset_watchdog_tb_top
`default_nettype wire
